// file: rtl/group_cfg_pkg.sv
// Package holding the layout and constants of the group settings word.
package group_cfg_pkg;
	// ==========================================================
	// Field positions of the group settings word.
	localparam int THR_LSB = 16;
	localparam int THR_W = 6;
	localparam int SYNC_SEL_BIT = 15;
	localparam int POLL_LSB = 10;
	localparam int TX_INH_BIT = 9;
	localparam int RX_INH_BIT = 8;
	localparam int PVA_BIT = 7;
	// Bits that hold a setting; all others are reserved and ignored.
	localparam logic [31:0] USED_MASK = 32'h003f_8f80;
	// Value of the settings word after reset.
	localparam logic [31:0] WORD_RESET = 32'h0000_0400;
	// ==========================================================
	// Service request codes and widths.
	localparam logic [4:0] SREQ_READ_GROUP = 5'h12;
	localparam int CH_W = 5;
	localparam int CHANNELS = 32;
	// Sync event counts between polls for selector values 1, 2, 3.
	localparam logic [6:0] POLL_EVERY_16 = 7'h10;
	localparam logic [6:0] POLL_EVERY_32 = 7'h20;
	localparam logic [6:0] POLL_EVERY_64 = 7'h40;
endpackage

// file: rtl/group_config_descriptor.sv
// Group settings word and the control decisions that it steers.
`timescale 1ns/1ps
module group_config_descriptor
	import group_cfg_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic sreq_valid,
	input wire logic [4:0] sreq_code,
	input wire logic mem_word_valid,
	input wire logic [31:0] mem_word,
	input wire logic line_clk_present,
	input wire logic map_load_req,
	input wire logic [5:0] unit_error_monitor_count,
	input wire logic slot_wrap,
	input wire logic tx_frame_sync_in,
	input wire logic rx_frame_sync_in,
	input wire logic chan_activate,
	input wire logic tx_buffer_done,
	input wire logic rx_buffer_filled,
	input wire logic protect_violation,
	input wire logic [4:0] service_chan,
	output logic [31:0] group_settings_word,
	output logic fetch_busy,
	output logic map_load_go,
	output logic unit_error_irq,
	output logic frame_sync_event,
	output logic chan_start_ok,
	output logic poll_go,
	output logic tx_status_write,
	output logic rx_status_write,
	output logic group_reset,
	output logic chan_deact,
	output logic [4:0] chan_deact_num
);
	import group_cfg_pkg::*;

	// ==========================================================
	// Pin synchronisers and field views.
	logic [1:0] tx_frame_sync_in_s_r, rx_frame_sync_in_s_r, lclk_s_r;
	logic sync_prev_r;
	logic sync_sel, tx_inh, rx_inh, pva;
	logic [1:0] poll_sel;
	logic [5:0] threshold;
	logic sync_in_rise, sync_ev;

	// Two flops for each frame sync pin and the line clock input, then a rise detector on the sync pins.
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			tx_frame_sync_in_s_r <= 2'h0;
			rx_frame_sync_in_s_r <= 2'h0;
			lclk_s_r <= 2'h0;
			sync_prev_r <= 1'b0;
		end
		else
		begin
			tx_frame_sync_in_s_r <= {tx_frame_sync_in_s_r[0], tx_frame_sync_in};
			rx_frame_sync_in_s_r <= {rx_frame_sync_in_s_r[0], rx_frame_sync_in};
			lclk_s_r <= {lclk_s_r[0], line_clk_present};
			sync_prev_r <= tx_frame_sync_in_s_r[1] | rx_frame_sync_in_s_r[1];
		end
	end

	// Fields read from the stored word; reserved bits never reach logic.
	always_comb
	begin
		threshold = group_settings_word[THR_LSB +: THR_W];
		sync_sel = group_settings_word[SYNC_SEL_BIT];
		poll_sel = group_settings_word[POLL_LSB +: 2];
		tx_inh = group_settings_word[TX_INH_BIT];
		rx_inh = group_settings_word[RX_INH_BIT];
		pva = group_settings_word[PVA_BIT];
		sync_in_rise = (tx_frame_sync_in_s_r[1] | rx_frame_sync_in_s_r[1]) & ~sync_prev_r;
		// Select the frame sync source.
		sync_ev = sync_sel ? sync_in_rise : slot_wrap;
	end

	// Maps the poll selector to its event count.
	function automatic logic [6:0] poll_limit(input logic [1:0] sel);
		unique case (sel)
			2'h1: poll_limit = POLL_EVERY_16;
			2'h2: poll_limit = POLL_EVERY_32;
			2'h3: poll_limit = POLL_EVERY_64;
			default: poll_limit = POLL_EVERY_16; // Unsupported value 0.
		endcase
	endfunction

	// ==========================================================
	// Descriptor fetch state machine.
	typedef enum logic [0:0] {IDLE, FETCH} fetch_t;
	fetch_t st_r, st_nxt;
	logic [31:0] word_nxt;

	// Request 18 waits for the memory word, then stores it.
	always_comb
	begin
		st_nxt = st_r;
		word_nxt = group_settings_word;
		unique case (st_r)
			IDLE:
				if (sreq_valid && sreq_code == SREQ_READ_GROUP)
					st_nxt = FETCH;
			FETCH:
				if (mem_word_valid)
				begin
					word_nxt = mem_word & USED_MASK;
					st_nxt = IDLE;
				end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			st_r <= IDLE;
			group_settings_word <= WORD_RESET;
		end
		else
		begin
			st_r <= st_nxt;
			group_settings_word <= word_nxt;
		end
	end

	// ==========================================================
	// Event outputs and poll pacing.
	logic [6:0] poll_cnt_r, poll_cnt_nxt;
	logic start_armed_r, start_armed_nxt;
	logic map_go_nxt, irq_nxt, poll_nxt, txw_nxt, rxw_nxt;
	logic grst_nxt, cdeact_nxt, start_nxt;
	logic [4:0] cnum_nxt;

	// Next values of the decision outputs but frame_sync_event and fetch_busy, one group per setting plus the map load gate.
	always_comb
	begin
		map_go_nxt = map_load_req & lclk_s_r[1];
		irq_nxt = unit_error_monitor_count > threshold;
		poll_cnt_nxt = poll_cnt_r;
		poll_nxt = 1'b0;
		if (sync_ev)
		begin
			if (poll_cnt_r + 7'h1 >= poll_limit(poll_sel))
			begin
				poll_cnt_nxt = 7'h0;
				poll_nxt = 1'b1;
			end
			else
				poll_cnt_nxt = poll_cnt_r + 7'h1;
		end
		// Activation arms; the selected sync event releases the start.
		start_armed_nxt = start_armed_r | chan_activate;
		start_nxt = 1'b0;
		if ((start_armed_r | chan_activate) && sync_ev)
		begin
			start_nxt = 1'b1;
			start_armed_nxt = 1'b0;
		end
		txw_nxt = tx_buffer_done & ~tx_inh;
		rxw_nxt = rx_buffer_filled & ~rx_inh;
		grst_nxt = protect_violation & ~pva;
		cdeact_nxt = protect_violation & pva;
		cnum_nxt = protect_violation ? service_chan : chan_deact_num;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			poll_cnt_r <= 7'h0;
			start_armed_r <= 1'b0;
			map_load_go <= 1'b0;
			unit_error_irq <= 1'b0;
			frame_sync_event <= 1'b0;
			chan_start_ok <= 1'b0;
			poll_go <= 1'b0;
			tx_status_write <= 1'b0;
			rx_status_write <= 1'b0;
			group_reset <= 1'b0;
			chan_deact <= 1'b0;
			chan_deact_num <= 5'h00;
			fetch_busy <= 1'b0;
		end
		else
		begin
			poll_cnt_r <= poll_cnt_nxt;
			start_armed_r <= start_armed_nxt;
			map_load_go <= map_go_nxt;
			unit_error_irq <= irq_nxt;
			frame_sync_event <= sync_ev;
			chan_start_ok <= start_nxt;
			poll_go <= poll_nxt;
			tx_status_write <= txw_nxt;
			rx_status_write <= rxw_nxt;
			group_reset <= grst_nxt;
			chan_deact <= cdeact_nxt;
			chan_deact_num <= cnum_nxt;
			fetch_busy <= (st_nxt == FETCH);
		end
	end

	// ==========================================================
	// Checks on the decisions above.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	map_gate_a: assert property (map_load_go |-> $past(lclk_s_r[1]))
		else $error("map load without line clock");
	irq_thr_a: assert property (
		(unit_error_monitor_count > threshold) |=> unit_error_irq)
		else $error("threshold exceeded without interrupt");
	wrap_sel_a: assert property (
		(!sync_sel && slot_wrap) |=> frame_sync_event)
		else $error("slot wrap not taken as sync");
	ext_sel_a: assert property (
		(sync_sel && !sync_in_rise) |=> !frame_sync_event)
		else $error("sync event without frame sync rise");
	poll_pace_a: assert property (poll_go |-> frame_sync_event)
		else $error("poll without sync event");
	start_gate_a: assert property (chan_start_ok |-> frame_sync_event)
		else $error("channel start without sync event");
	tx_inh_a: assert property (tx_status_write |-> !$past(tx_inh))
		else $error("tx status written while inhibited");
	tx_wb_a: assert property ((tx_buffer_done && !tx_inh) |=> tx_status_write)
		else $error("tx status write back missing");
	rx_inh_a: assert property (rx_status_write |-> !$past(rx_inh))
		else $error("rx status written while inhibited");
	rx_wb_a: assert property (
		(rx_buffer_filled && !rx_inh) |=> rx_status_write)
		else $error("rx status write back missing");
	pv_grp_a: assert property ((protect_violation && !pva) |=> group_reset)
		else $error("violation did not reset group");
	pv_chan_a: assert property (
		(protect_violation && pva) |=> chan_deact && !group_reset)
		else $error("violation did not deactivate channel");
	fetch_load_a: assert property (
		(st_r == FETCH && mem_word_valid) |=>
		group_settings_word == ($past(mem_word) & USED_MASK))
		else $error("fetched word not stored");
endmodule

// file: tb/host_mem_model.sv
// Shared memory model that answers settings word fetches after a delay.
`timescale 1ns/1ps
module host_mem_model
(
	input wire logic clk,
	input wire logic fetch_busy,
	input wire logic [31:0] word,
	input wire logic [1:0] delay,
	output logic mem_word_valid,
	output logic [31:0] mem_word
);
	logic [1:0] wait_cnt;
	// ==========================================================
	// Reply
	// The word shows only in its valid cycle; otherwise the bus toggles.
	initial
	begin
		mem_word_valid = 1'b0;
		mem_word = 32'h0000_0000;
		wait_cnt = 2'h0;
	end
	// The reply waits a set number of cycles, then stands one cycle.
	always @(posedge clk)
	begin
		#1;
		mem_word = ~mem_word;
		mem_word_valid = 1'b0;
		if (fetch_busy === 1'b1 && wait_cnt == delay)
		begin
			mem_word_valid = 1'b1;
			mem_word = word;
			wait_cnt = 2'h0;
		end
		else if (fetch_busy === 1'b1)
			wait_cnt = wait_cnt + 2'h1;
	end
endmodule

// file: tb/testbench.sv
// Self-checking bench for the group settings word block.
`timescale 1ns/1ps
module testbench;
	import group_cfg_pkg::*;
	logic clk, rst_b, sreq_valid, mem_word_valid, line_clk_present;
	logic map_load_req, slot_wrap, tx_frame_sync_in, rx_frame_sync_in;
	logic chan_activate, tx_buffer_done, rx_buffer_filled;
	logic protect_violation, fetch_busy, map_load_go, unit_error_irq;
	logic frame_sync_event, chan_start_ok, poll_go, tx_status_write;
	logic rx_status_write, group_reset, chan_deact;
	logic [4:0] sreq_code, service_chan, chan_deact_num;
	logic [5:0] unit_error_monitor_count;
	logic [31:0] mem_word, group_settings_word, word, seed, w;
	logic [1:0] delay;
	int miscompares, checks, i, k, n;
	group_config_descriptor uut (.clk, .rst_b, .sreq_valid, .sreq_code,
		.mem_word_valid, .mem_word, .line_clk_present, .map_load_req,
		.unit_error_monitor_count, .slot_wrap, .tx_frame_sync_in,
		.rx_frame_sync_in, .chan_activate, .tx_buffer_done,
		.rx_buffer_filled, .protect_violation, .service_chan,
		.group_settings_word, .fetch_busy, .map_load_go, .unit_error_irq,
		.frame_sync_event, .chan_start_ok, .poll_go, .tx_status_write,
		.rx_status_write, .group_reset, .chan_deact, .chan_deact_num);
	host_mem_model host (.clk, .fetch_busy, .word, .delay,
		.mem_word_valid, .mem_word);
	// ==========================================================
	// Helpers
	// Next value of the random source.
	function logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Stored word is the fetched word with the reserved bits cleared.
	function logic [31:0] exp_word(input logic [31:0] v);
		return v & USED_MASK;
	endfunction
	// Sync events between polls for a poll selector value.
	function int poll_every(input int sel);
		if (sel == 2)
			return POLL_EVERY_32;
		else if (sel == 3)
			return POLL_EVERY_64;
		else
			return POLL_EVERY_16;
	endfunction
	task step;
		@(posedge clk);
		#1;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		checks++;
		if (s !== e)
		begin
			miscompares++;
			$display("CHECK FAILED %s exp %h got %h", n, e, s);
		end
	endtask
	// Fetches a word through a service request and checks it is stored.
	task fetch(input logic [31:0] v);
		word = v;
		seed = lfsr(seed);
		delay = seed[1:0];
		sreq_valid = 1'b1;
		sreq_code = SREQ_READ_GROUP;
		step;
		sreq_valid = 1'b0;
		chk("fetch_busy", 1, fetch_busy);
		for (k = 0; k < 20 && fetch_busy !== 1'b0; k++)
			step;
		chk("word", exp_word(v), group_settings_word);
	endtask
	task close_out;
		if (miscompares == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ==========================================================
	// Clock, watchdog and stimulus
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Cuts a hang short well past the expected run length.
	initial
	begin
		#2000000;
		miscompares++;
		close_out;
	end
	initial
	begin
		{sreq_valid, line_clk_present, map_load_req, slot_wrap} = 4'h0;
		{tx_frame_sync_in, rx_frame_sync_in, chan_activate} = 3'h0;
		{tx_buffer_done, rx_buffer_filled, protect_violation} = 3'h0;
		{sreq_code, service_chan, unit_error_monitor_count} = 16'h0000;
		word = 32'h0000_0000;
		delay = 2'h0;
		miscompares = 0;
		checks = 0;
		seed = 32'h8939;
		rst_b = 1'b0;
		repeat (6) @(posedge clk);
		#1;
		rst_b = 1'b1;
		chk("reset word", WORD_RESET, group_settings_word);
		// Slot wraps pace sync events and polls every sixteenth.
		chan_activate = 1'b1;
		step;
		chan_activate = 1'b0;
		for (i = 1; i <= 16; i++)
		begin
			slot_wrap = 1'b1;
			step;
			chk("sync event", 1, frame_sync_event);
			chk("start", i == 1, chan_start_ok);
			chk("poll", i == POLL_EVERY_16, poll_go);
		end
		slot_wrap = 1'b0;
		// A request code other than the fetch code is ignored.
		sreq_valid = 1'b1;
		sreq_code = 5'h11;
		step;
		sreq_valid = 1'b0;
		chk("busy other code", 0, fetch_busy);
		// Map loads wait for the line clock.
		map_load_req = 1'b1;
		step;
		chk("map no clock", 0, map_load_go);
		map_load_req = 1'b0;
		line_clk_present = 1'b1;
		repeat (3) step;
		map_load_req = 1'b1;
		step;
		chk("map clock", 1, map_load_go);
		map_load_req = 1'b0;
		// Random words steer write backs, violations and the threshold.
		for (i = 0; i < 6; i++)
		begin
			seed = lfsr(seed);
			w = seed & 32'hffff_7fff;
			if (w[11:10] == 2'h0)
				w[11:10] = 2'h2;
			fetch(w);
			seed = lfsr(seed);
			unit_error_monitor_count = i < 2 ? 6'(w[21:16] + i) :
				seed[29:24];
			service_chan = seed[4:0];
			{tx_buffer_done, rx_buffer_filled, protect_violation} = 3'h7;
			step;
			{tx_buffer_done, rx_buffer_filled, protect_violation} = 3'h0;
			chk("tx write", !w[9], tx_status_write);
			chk("rx write", !w[8], rx_status_write);
			chk("group reset", !w[7], group_reset);
			chk("deact", w[7], chan_deact);
			if (w[7])
				chk("deact num", seed[4:0], chan_deact_num);
			chk("irq", unit_error_monitor_count > w[21:16],
				unit_error_irq);
		end
		// Selectors 2 and 3 stretch the poll spacing to 32 and 64 wraps.
		for (n = 2; n <= 3; n++)
		begin
			fetch(32'(n) << POLL_LSB);
			slot_wrap = 1'b1;
			for (i = 1; i <= 64; i++)
			begin
				step;
				chk("poll spacing", i % poll_every(n) == 0, poll_go);
			end
			slot_wrap = 1'b0;
		end
		// With the pin selected, wraps no longer count as sync events.
		fetch(32'h0000_8400);
		// The receive pin is tried first, then the transmit pin.
		for (k = 0; k < 2; k++)
		begin
			chan_activate = 1'b1;
			slot_wrap = 1'b1;
			step;
			{chan_activate, slot_wrap} = 2'h0;
			chk("wrap ignored", 0, frame_sync_event);
			{tx_frame_sync_in, rx_frame_sync_in} = k ? 2'h2 : 2'h1;
			for (i = 1; i <= 4; i++)
			begin
				step;
				chk("pin event", i == 3, frame_sync_event);
				chk("pin start", i == 3, chan_start_ok);
			end
			// Let the synchronisers and the rise detector settle low.
			{tx_frame_sync_in, rx_frame_sync_in} = 2'h0;
			repeat (3) step;
		end
		close_out;
	end
endmodule
